// ==== src/ubf_pkg.sv ====
// constants, register map and carrier types of the serial transceiver
// assumes one 25 MHz clock and an avalon-mm slave with byte addresses
package ubf_pkg;
	localparam logic [31:0] ADDR_DATA  = 32'h4000_8000;
	localparam logic [31:0] ADDR_LINE  = 32'h4000_800c;
	localparam logic [31:0] ADDR_LSTAT = 32'h4000_8014;
	localparam logic [31:0] ADDR_DIV   = 32'h4000_8020;
	localparam logic [31:0] ADDR_FRAC  = 32'h4000_8024;
	localparam logic [31:0] ADDR_GAP   = 32'h4000_8030;
	localparam logic [31:0] ADDR_TXA   = 32'h4000_8040;
	localparam logic [31:0] ADDR_TXC   = 32'h4000_8044;
	localparam logic [31:0] ADDR_RXA   = 32'h4000_8048;
	localparam logic [31:0] ADDR_RXC   = 32'h4000_804c;
	localparam logic [31:0] ADDR_DCTL  = 32'h4000_8050;
	localparam logic [31:0] ADDR_DSTAT = 32'h4000_8054;

	localparam int LSTAT_EMPTY = 6;
	localparam int LSTAT_HOLD  = 5;
	localparam int LSTAT_READY = 0;
	localparam int DCTL_TXEN   = 0;
	localparam int DCTL_RXEN   = 1;
	localparam int DCTL_TXIE   = 2;
	localparam int DCTL_RXIE   = 3;
	localparam int DSTAT_TX    = 0;
	localparam int DSTAT_RX    = 1;

	localparam logic [3:0]  SAMPLE_TICK  = 4'h6;
	localparam logic [3:0]  LAST_TICK    = 4'hf;
	localparam logic [11:0] TICKS_BIT    = 12'h010;
	localparam logic [11:0] TICKS_STOP15 = 12'h018;
	localparam logic [11:0] TICKS_STOP2  = 12'h020;
	localparam logic [1:0]  LEN_5        = 2'h0;

	typedef struct packed {
		logic       stick;
		logic       even;
		logic       parity_insert_enable;
		logic       stop_long;
		logic [1:0] len;
	} ubf_line_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} ubf_rd_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
		logic [7:0]  data;
	} ubf_wr_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GAP} ubf_tx_t;
	typedef enum logic [0:0] {RX_IDLE, RX_BUSY} ubf_rx_t;
endpackage

// ==== src/ubf_uart.sv ====
// serial transceiver with fractional baud generator and two dma counters
// assumes avalon-mm master on mclk, rxd from a pin, dma engine on mclk
`timescale 1ns/1ps
module ubf_uart
	import ubf_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [31:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rxd,
	output logic             txd,
	output ubf_rd_t          tx_dma,
	input  wire logic        tx_dma_ack,
	input  wire logic [7:0]  tx_dma_data,
	output ubf_wr_t          rx_dma,
	input  wire logic        rx_dma_ack,
	output logic             dma_irq
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction

	logic        ack_q;
	logic [31:0] rdata_q;
	logic [15:0] divisor_q;
	logic [7:0]  fstep_q;
	logic [7:0]  gap_q;
	ubf_line_t   line_q;
	logic [3:0]  dctl_q;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rd_mux;

	// bus slave: one wait cycle, then answer
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign wr_en           = avs_write & ack_q;
	assign rd_en           = avs_read & ack_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read | avs_write) & ~ack_q;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			divisor_q <= 16'h0000;
			fstep_q   <= 8'h00;
			gap_q     <= 8'h00;
			line_q    <= '0;
			dctl_q    <= 4'h0;
		end else if (wr_en) begin
			case (avs_address)
				ADDR_DIV:  divisor_q <= 16'(merge({16'h0000, divisor_q}, avs_writedata,
					avs_byteenable));
				ADDR_FRAC: fstep_q <= 8'(merge({24'h0, fstep_q}, avs_writedata, avs_byteenable));
				ADDR_GAP:  gap_q <= 8'(merge({24'h0, gap_q}, avs_writedata, avs_byteenable));
				ADDR_LINE: line_q <= 6'(merge({26'h0, line_q}, avs_writedata, avs_byteenable));
				ADDR_DCTL: dctl_q <= 4'(merge({28'h0, dctl_q}, avs_writedata, avs_byteenable));
				default: ;
			endcase
		end
	end

	// baud generator
	logic        half_q;
	logic [16:0] div_cnt_q;
	logic [7:0]  facc_q;
	logic        stretch_q;
	logic [16:0] period;
	logic        tick;
	logic [8:0]  facc_sum;

	assign period   = {1'b0, divisor_q} + {16'h0000, stretch_q};
	assign tick     = half_q & (divisor_q != 16'h0000) & (div_cnt_q >= period - 17'h00001);
	assign facc_sum = {1'b0, facc_q} + {1'b0, fstep_q};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			half_q <= 1'b0;
		else
			half_q <= ~half_q;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			div_cnt_q <= '0;
		else if (tick)
			div_cnt_q <= '0;
		else if (half_q)
			div_cnt_q <= div_cnt_q + 17'h00001;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			facc_q    <= 8'h00;
			stretch_q <= 1'b0;
		end else if (tick) begin
			facc_q    <= facc_sum[7:0];
			stretch_q <= facc_sum[8];
		end
	end

	// receiver
	logic       rx_s1_q;
	logic       rx_s2_q;
	logic       rx_s3_q;
	ubf_rx_t    rx_state_q;
	logic [3:0] rx_sub_q;
	logic [3:0] rx_idx_q;
	logic [7:0] rx_sh_q;
	logic [7:0] rx_hold_q;
	logic       rx_full_q;
	logic [3:0] rx_stop_idx;
	logic       rx_store;
	logic       rx_take;

	assign rx_stop_idx = 4'd6 + {2'b00, line_q.len} + {3'b000, line_q.parity_insert_enable};
	assign rx_store = (rx_state_q == RX_BUSY) & tick & (rx_sub_q == SAMPLE_TICK)
		& (rx_idx_q == rx_stop_idx);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
		end else begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q   <= 4'h0;
			rx_idx_q   <= 4'h0;
			rx_sh_q    <= 8'h00;
		end else begin
			case (rx_state_q)
				RX_IDLE: begin
					if (rx_s3_q & ~rx_s2_q) begin
						rx_state_q <= RX_BUSY;
						rx_sub_q   <= 4'h0;
						rx_idx_q   <= 4'h0;
					end
				end
				RX_BUSY: begin
					if (tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == LAST_TICK)
							rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_sub_q == SAMPLE_TICK) begin
							if (rx_idx_q == 4'h0 && rx_s2_q)
								rx_state_q <= RX_IDLE;
							else if (rx_idx_q == rx_stop_idx)
								rx_state_q <= RX_IDLE;
							else if (rx_idx_q != 4'h0 && rx_idx_q <= 4'd5 + {2'b00, line_q.len})
								rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
						end
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// one-entry receive holding register; a new word wins over a take
	assign rx_take = (rd_en & (avs_address == ADDR_DATA)) | (rx_dma.req & rx_dma_ack);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rx_hold_q <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (rx_store) begin
			rx_hold_q <= rx_sh_q >> (2'h3 - line_q.len);
			rx_full_q <= 1'b1;
		end else if (rx_take) begin
			rx_full_q <= 1'b0;
		end
	end

	// transmitter
	ubf_tx_t     tx_state_q;
	logic [11:0] tx_tcnt_q;
	logic [11:0] tx_limit;
	logic [7:0]  tx_sh_q;
	logic [2:0]  tx_bit_q;
	logic        tx_par_q;
	logic [7:0]  hold_q;
	logic        hold_full_q;
	logic        slot_end;
	logic        load_shift;
	logic        hold_wr;
	logic        txd_q;
	logic [7:0]  len_mask;
	logic        dpar;

	assign len_mask = 8'hff >> (2'h3 - line_q.len);
	assign dpar     = ^(hold_q & len_mask);

	always_comb begin
		case (tx_state_q)
			TX_STOP: begin
				if (!line_q.stop_long)
					tx_limit = TICKS_BIT;
				else if (line_q.len == LEN_5)
					tx_limit = TICKS_STOP15;
				else
					tx_limit = TICKS_STOP2;
			end
			TX_GAP:  tx_limit = {gap_q, 4'h0};
			default: tx_limit = TICKS_BIT;
		endcase
	end

	// no wrap when the gap is cut to zero mid-gap
	assign slot_end   = tick & (tx_tcnt_q + 12'h001 >= tx_limit);
	assign load_shift = (tx_state_q == TX_IDLE) & hold_full_q;
	assign hold_wr    = (wr_en & (avs_address == ADDR_DATA)) | (tx_dma.req & tx_dma_ack);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_state_q <= TX_IDLE;
			tx_tcnt_q  <= 12'h000;
			tx_sh_q    <= 8'h00;
			tx_bit_q   <= 3'h0;
			tx_par_q   <= 1'b0;
		end else begin
			if (load_shift || slot_end)
				tx_tcnt_q <= 12'h000;
			else if (tick)
				tx_tcnt_q <= tx_tcnt_q + 12'h001;
			case (tx_state_q)
				TX_IDLE: begin
					if (hold_full_q) begin
						tx_state_q <= TX_START;
						tx_sh_q    <= hold_q;
						tx_bit_q   <= 3'd4 + {1'b0, line_q.len};
						if (line_q.stick)
							tx_par_q <= ~line_q.even;
						else
							tx_par_q <= line_q.even ? dpar : ~dpar;
					end
				end
				TX_START: if (slot_end) tx_state_q <= TX_DATA;
				TX_DATA: begin
					if (slot_end) begin
						tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
						tx_bit_q <= tx_bit_q - 3'h1;
						if (tx_bit_q == 3'h0)
							tx_state_q <= line_q.parity_insert_enable ? TX_PAR : TX_STOP;
					end
				end
				TX_PAR:  if (slot_end) tx_state_q <= TX_STOP;
				TX_STOP: begin
					if (slot_end)
						tx_state_q <= (gap_q == 8'h00) ? TX_IDLE : TX_GAP;
				end
				TX_GAP:  if (slot_end) tx_state_q <= TX_IDLE;
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			txd_q <= 1'b1;
		else begin
			case (tx_state_q)
				TX_START: txd_q <= 1'b0;
				TX_DATA:  txd_q <= tx_sh_q[0];
				TX_PAR:   txd_q <= tx_par_q;
				default:  txd_q <= 1'b1;
			endcase
		end
	end
	assign txd = txd_q;

	// one-entry transmit holding register; a write wins over the shifter load
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_q      <= 8'h00;
			hold_full_q <= 1'b0;
		end else if (hold_wr) begin
			hold_q      <= (wr_en & (avs_address == ADDR_DATA)) ? avs_writedata[7:0] : tx_dma_data;
			hold_full_q <= 1'b1;
		end else if (load_shift) begin
			hold_full_q <= 1'b0;
		end
	end

	logic tx_holding_empty_flag;
	logic tx_shifter_empty_flag;
	assign tx_holding_empty_flag = ~hold_full_q;
	assign tx_shifter_empty_flag = ~hold_full_q & ((tx_state_q == TX_IDLE) | (tx_state_q == TX_GAP));

	// dma channels
	logic [31:0] txa_q;
	logic [15:0] txc_q;
	logic [31:0] rxa_q;
	logic [15:0] rxc_q;
	logic        tx_dma_done_flag;
	logic        rx_dma_done_flag;
	logic        tx_fire;
	logic        rx_fire;

	assign tx_dma.req  = dctl_q[DCTL_TXEN] & ~hold_full_q & (txc_q != 16'h0000);
	assign tx_dma.addr = txa_q;
	assign rx_dma.req  = dctl_q[DCTL_RXEN] & rx_full_q & (rxc_q != 16'h0000);
	assign rx_dma.addr = rxa_q;
	assign rx_dma.data = rx_hold_q;
	assign tx_fire     = tx_dma.req & tx_dma_ack;
	assign rx_fire     = rx_dma.req & rx_dma_ack;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txa_q <= 32'h0000_0000;
			txc_q <= 16'h0000;
		end else if (tx_fire) begin
			txa_q <= txa_q + 32'h0000_0001;
			txc_q <= txc_q - 16'h0001;
		end else if (wr_en && avs_address == ADDR_TXA) begin
			txa_q <= merge(txa_q, avs_writedata, avs_byteenable);
		end else if (wr_en && avs_address == ADDR_TXC) begin
			txc_q <= 16'(merge({16'h0000, txc_q}, avs_writedata, avs_byteenable));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxa_q <= 32'h0000_0000;
			rxc_q <= 16'h0000;
		end else if (rx_fire) begin
			rxa_q <= rxa_q + 32'h0000_0001;
			rxc_q <= rxc_q - 16'h0001;
		end else if (wr_en && avs_address == ADDR_RXA) begin
			rxa_q <= merge(rxa_q, avs_writedata, avs_byteenable);
		end else if (wr_en && avs_address == ADDR_RXC) begin
			rxc_q <= 16'(merge({16'h0000, rxc_q}, avs_writedata, avs_byteenable));
		end
	end

	// done flags: last word into holding register, last word stored; set wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_dma_done_flag <= 1'b0;
			rx_dma_done_flag <= 1'b0;
		end else begin
			if (tx_fire && txc_q == 16'h0001)
				tx_dma_done_flag <= 1'b1;
			else if (wr_en && avs_address == ADDR_DSTAT && avs_byteenable[0] &&
				avs_writedata[DSTAT_TX])
				tx_dma_done_flag <= 1'b0;
			if (rx_fire && rxc_q == 16'h0001)
				rx_dma_done_flag <= 1'b1;
			else if (wr_en && avs_address == ADDR_DSTAT && avs_byteenable[0] &&
				avs_writedata[DSTAT_RX])
				rx_dma_done_flag <= 1'b0;
		end
	end

	assign dma_irq = (tx_dma_done_flag & dctl_q[DCTL_TXIE]) |
		(rx_dma_done_flag & dctl_q[DCTL_RXIE]);

	// read mux, sampled in the wait cycle
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			ADDR_DATA:  rd_mux = {24'h0, rx_hold_q};
			ADDR_LINE:  rd_mux = {26'h0, line_q};
			ADDR_LSTAT: begin
				rd_mux[LSTAT_EMPTY] = tx_shifter_empty_flag;
				rd_mux[LSTAT_HOLD]  = tx_holding_empty_flag;
				rd_mux[LSTAT_READY] = rx_full_q;
			end
			ADDR_DIV:   rd_mux = {16'h0, divisor_q};
			ADDR_FRAC:  rd_mux = {24'h0, fstep_q};
			ADDR_GAP:   rd_mux = {24'h0, gap_q};
			ADDR_TXA:   rd_mux = txa_q;
			ADDR_TXC:   rd_mux = {16'h0, txc_q};
			ADDR_RXA:   rd_mux = rxa_q;
			ADDR_RXC:   rd_mux = {16'h0, rxc_q};
			ADDR_DCTL:  rd_mux = {28'h0, dctl_q};
			ADDR_DSTAT: begin
				rd_mux[DSTAT_TX] = tx_dma_done_flag;
				rd_mux[DSTAT_RX] = rx_dma_done_flag;
			end
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata_q <= 32'h0000_0000;
		else if (avs_read && !ack_q)
			rdata_q <= rd_mux;
	end

	// checks
	logic [17:0] tk_gap_q;
	logic        tk_seen_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tk_gap_q  <= '0;
			tk_seen_q <= 1'b0;
		end else begin
			tk_gap_q  <= tick ? 18'h00001 : tk_gap_q + 18'h00001;
			if (wr_en && (avs_address == ADDR_DIV || avs_address == ADDR_FRAC))
				tk_seen_q <= 1'b0;
			else if (tick)
				tk_seen_q <= 1'b1;
		end
	end

	tick_spacing_a: assert property (@(posedge mclk) disable iff (rst)
		tick && tk_seen_q |-> tk_gap_q == {period, 1'b0})
		else $error("baud tick spacing wrong");
	frac_stretch_a: assert property (@(posedge mclk) disable iff (rst)
		tick && facc_sum[8] |=> {stretch_q, facc_q} == $past(facc_sum))
		else $error("fraction wrap did not stretch");
	stretch_return_a: assert property (@(posedge mclk) disable iff (rst)
		tick && stretch_q && !facc_sum[8] |=> !stretch_q)
		else $error("stretch held too long");
	rx_start_edge_a: assert property (@(posedge mclk) disable iff (rst)
		rx_state_q == RX_IDLE && rx_s3_q && !rx_s2_q |=> rx_state_q == RX_BUSY && rx_sub_q == 4'h0)
		else $error("start edge missed");
	tx_idle_high_a: assert property (@(posedge mclk) disable iff (rst)
		$past(tx_state_q == TX_IDLE || tx_state_q == TX_GAP) |-> txd_q)
		else $error("line not high when idle");
	tx_start_low_a: assert property (@(posedge mclk) disable iff (rst)
		tx_state_q == TX_IDLE && hold_full_q |=> tx_state_q == TX_START ##1 !txd_q)
		else $error("start bit not low");
	tx_count_dec_a: assert property (@(posedge mclk) disable iff (rst)
		tx_fire |=> txc_q == $past(txc_q) - 16'h0001)
		else $error("tx count not decremented");
	tx_done_set_a: assert property (@(posedge mclk) disable iff (rst)
		tx_fire && txc_q == 16'h0001 |=> tx_dma_done_flag && txc_q == 16'h0000)
		else $error("tx done missing");
	rx_done_set_a: assert property (@(posedge mclk) disable iff (rst)
		rx_fire && rxc_q == 16'h0001 |=> rx_dma_done_flag && (!rx_full_q || $past(rx_store)))
		else $error("rx done missing");
	hold_empty_a: assert property (@(posedge mclk) disable iff (rst)
		load_shift && !hold_wr |=> tx_holding_empty_flag && tx_state_q == TX_START)
		else $error("holding empty flag late");
	gap_skip_a: assert property (@(posedge mclk) disable iff (rst)
		tx_state_q == TX_STOP && slot_end && gap_q == 8'h00 |=> tx_state_q == TX_IDLE)
		else $error("gap inserted when zero");

	tx_parity_c: cover property (@(posedge mclk) disable iff (rst)
		tx_state_q == TX_PAR ##1 tx_state_q == TX_PAR);
	rx_store_c: cover property (@(posedge mclk) disable iff (rst) rx_store);
	stretch_c: cover property (@(posedge mclk) disable iff (rst) tick && stretch_q);
	dma_done_c: cover property (@(posedge mclk) disable iff (rst) tx_dma_done_flag && rx_dma_done_flag);
endmodule

// ==== tb/ubf_remote.sv ====
// remote serial partner: decodes frames on txd, sends 8n1 frames on rxd
// assumes a fixed bit period in mclk cycles; rxd rests high like a pulled-up line
`timescale 1ns/1ps
module ubf_remote #(
	parameter int BIT_CYC = 64
) (
	input  wire logic       mclk,
	input  wire logic       txd,
	input  wire logic [3:0] nslots,
	output logic            rxd
);
	int          cyc = 0;
	int          starts[$];
	logic [11:0] frames[$];
	logic [11:0] f;

	always @(posedge mclk) begin
		cyc <= cyc + 1;
	end

	// sample each slot mid-bit, stop sample ends the frame
	initial begin
		rxd = 1'b1;
		forever begin
			@(negedge txd);
			starts.push_back(cyc);
			f = '1;
			repeat (BIT_CYC / 2) @(posedge mclk);
			for (int i = 0; i < nslots; i++) begin
				if (i != 0) repeat (BIT_CYC) @(posedge mclk);
				f[i] = txd;
			end
			frames.push_back(f);
		end
	end

	task automatic send(input logic [7:0] d);
		logic [9:0] b;
		b = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk);
			rxd <= b[i];
			repeat (BIT_CYC - 1) @(posedge mclk);
		end
	endtask
endmodule

// ==== tb/ubf_uart_tb.sv ====
// testbench: registers, framed transmit, receive and both dma channels
// assumes the ubf_uart top, the remote partner model and a 25 MHz clock
`timescale 1ns/1ps
module ubf_uart_tb
	import ubf_pkg::*;
;
	localparam int DIV  = 2;
	localparam int TICK = 2 * DIV;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] avs_address = '0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rxd;
	logic        txd;
	ubf_rd_t     tx_dma;
	ubf_wr_t     rx_dma;
	logic        tx_dma_ack = 1'b0;
	logic [7:0]  tx_dma_data = '0;
	logic        rx_dma_ack = 1'b0;
	logic        dma_irq;
	logic [3:0]  nslots = 4'ha;
	logic [7:0]  mem [16];
	logic [31:0] q;
	int          failures = 0;
	int          compares = 0;
	int          nbits;
	int          tk;
	int          cyc;
	int          sp;
	logic [7:0]  lines [7] = '{8'h04, 8'h19, 8'h0e, 8'h2b, 8'h3b, 8'h03, 8'h03};
	logic [7:0]  gaps  [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
	logic [7:0]  fracs [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
	logic [7:0]  datas [7] = '{8'h15, 8'h2a, 8'h4b, 8'h96, 8'h96, 8'h5a, 8'hff};

	always #20 mclk = ~mclk;

	ubf_uart u_ubf_uart (
		.mclk           (mclk),
		.rst            (rst),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (4'hf),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.rxd            (rxd),
		.txd            (txd),
		.tx_dma         (tx_dma),
		.tx_dma_ack     (tx_dma_ack),
		.tx_dma_data    (tx_dma_data),
		.rx_dma         (rx_dma),
		.rx_dma_ack     (rx_dma_ack),
		.dma_irq        (dma_irq)
	);

	ubf_remote #(.BIT_CYC(32 * DIV)) u_ubf_remote (
		.mclk  (mclk),
		.txd   (txd),
		.nslots(nslots),
		.rxd   (rxd)
	);

	// memory side of both dma channels, one-cycle ack per request
	always @(posedge mclk) begin
		tx_dma_ack <= 1'b0;
		rx_dma_ack <= 1'b0;
		if (tx_dma.req === 1'b1 && !tx_dma_ack) begin
			tx_dma_ack  <= 1'b1;
			tx_dma_data <= mem[tx_dma.addr[3:0]];
		end
		if (rx_dma.req === 1'b1 && !rx_dma_ack) begin
			rx_dma_ack                <= 1'b1;
			mem[rx_dma.addr[3:0]]     <= rx_dma.data;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) failures++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic poll(input logic [31:0] a, input int b);
		int n;
		n = 0;
		do begin
			rd(a);
			n++;
		end while (q[b] !== 1'b1 && n < 2000);
		if (n >= 2000) failures++;
	endtask

	task automatic wait_frames(input int k);
		int n;
		n = 0;
		while (u_ubf_remote.frames.size() < k && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 5000) failures++;
	endtask

	function automatic logic [11:0] frame_bits(input logic [7:0] d, input logic [7:0] ln);
		int          n;
		logic        p;
		logic [11:0] f;
		n = 5 + ln[1:0];
		f = '1;
		f[0] = 1'b0;
		p = 1'b0;
		for (int i = 0; i < n; i++) begin
			f[i + 1] = d[i];
			p ^= d[i];
		end
		if (ln[5]) p = ~ln[4];
		else if (!ln[4]) p = ~p;
		if (ln[3]) f[n + 1] = p;
		return f;
	endfunction

	initial begin
		#1600000;
		failures++;
		final_report();
	end

	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		chk(txd, 1'b1);
		rd(ADDR_DIV);
		chk(q, 32'h0);
		rd(ADDR_FRAC);
		chk(q, 32'h0);
		rd(ADDR_GAP);
		chk(q, 32'h0);
		rd(ADDR_LSTAT);
		chk(q, 32'h60);
		rd(32'h4000_8060);
		chk(q, 32'h0);
		wr(ADDR_LSTAT, 32'h0);
		rd(ADDR_LSTAT);
		chk(q, 32'h60);
		wr(ADDR_DIV, DIV);
		rd(ADDR_DIV);
		chk(q, DIV);
		$display("test registers done");
		// two characters back to back per setting, start-to-start spacing measured
		for (int k = 0; k < 7; k++) begin
			wr(ADDR_LINE, {24'h0, lines[k]});
			wr(ADDR_GAP, {24'h0, gaps[k]});
			wr(ADDR_FRAC, {24'h0, fracs[k]});
			nbits = 5 + lines[k][1:0];
			nslots = 4'(nbits + 2 + lines[k][3]);
			u_ubf_remote.starts.delete();
			u_ubf_remote.frames.delete();
			wr(ADDR_DATA, {24'h0, datas[k]});
			wr(ADDR_DATA, {24'h0, datas[k]});
			wait_frames(2);
			poll(ADDR_LSTAT, LSTAT_EMPTY);
			tk = 16 * (1 + nbits + lines[k][3]) + (lines[k][2] ? (nbits == 5 ? 24 : 32) : 16);
			cyc = tk * TICK + (fracs[k] != 0 ? tk : 0) + gaps[k] * 16 * TICK;
			sp = u_ubf_remote.starts[1] - u_ubf_remote.starts[0];
			chk((sp + 16) / 32, (cyc + 16) / 32);
			if (fracs[k] == 0) chk(u_ubf_remote.frames[1], frame_bits(datas[k], lines[k]));
		end
		$display("test framing done");
		wr(ADDR_FRAC, 32'h0);
		nslots = 4'ha;
		u_ubf_remote.send(8'ha5);
		poll(ADDR_LSTAT, LSTAT_READY);
		rd(ADDR_DATA);
		chk(q, 32'ha5);
		rd(ADDR_LSTAT);
		chk(q[LSTAT_READY], 1'b0);
		$display("test receive done");
		mem[0] = 8'h3c;
		mem[1] = 8'hc3;
		u_ubf_remote.frames.delete();
		wr(ADDR_TXA, 32'h0);
		wr(ADDR_TXC, 32'h2);
		wr(ADDR_DCTL, 32'h5);
		poll(ADDR_DSTAT, DSTAT_TX);
		rd(ADDR_LSTAT);
		chk(q[LSTAT_EMPTY], 1'b0);
		chk(dma_irq, 1'b1);
		rd(ADDR_TXC);
		chk(q, 32'h0);
		rd(ADDR_TXA);
		chk(q, 32'h2);
		wait_frames(2);
		chk(u_ubf_remote.frames[0], frame_bits(8'h3c, 8'h03));
		chk(u_ubf_remote.frames[1], frame_bits(8'hc3, 8'h03));
		wr(ADDR_DSTAT, 32'h1);
		@(posedge mclk);
		chk(dma_irq, 1'b0);
		$display("test transmit dma done");
		wr(ADDR_RXA, 32'h4);
		wr(ADDR_RXC, 32'h1);
		wr(ADDR_DCTL, 32'ha);
		u_ubf_remote.send(8'h5a);
		poll(ADDR_DSTAT, DSTAT_RX);
		chk(mem[4], 8'h5a);
		chk(rxd, 1'b1);
		chk(dma_irq, 1'b1);
		rd(ADDR_RXC);
		chk(q, 32'h0);
		$display("test receive dma done");
		final_report();
	end
endmodule
